// *** rtl/iec_irq_ctrl.sv ***
// interrupt flags, entry and return sequencer, external interrupt pin
`timescale 1ns/100ps

`include "iec_regs.svh"

module iec_irq_ctrl
  import iec_pkg::*;
#(
  parameter int NSRC = 29
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [NSRC-1:0] SRC_EVENT_I,
  input wire logic [NSRC-1:0] SRC_FLAG_CLR_I,
  input wire logic [NSRC-1:0] SRC_ENABLE_I,
  output logic [NSRC-1:0] SRC_FLAG_O,
  input wire logic EXT_PIN_I,
  input wire iec_ext_cfg_s EXT_CFG_I,
  input wire logic EXT_FLAG_ACK_I,
  output logic EXT_PIN_EVENT_FLAG_O,
  output logic EXT_PIN_LEVEL_O,
  output logic EXT_PULL_UP_EN_O,
  output logic EXT_PULL_DOWN_EN_O,
  input wire logic STOP_I,
  output logic STOP_WAKE_O,
  input wire iec_cpu_ctx_s CPU_CTX_I,
  input wire logic INSTR_DONE_I,
  input wire logic SWI_REQ_I,
  input wire logic RTI_REQ_I,
  input wire logic CCR_WR_I,
  input wire logic [7:0] CCR_WDATA_I,
  input wire logic SP_WR_I,
  input wire logic [15:0] SP_WDATA_I,
  output logic [7:0] CCR_O,
  output logic [15:0] SP_O,
  output iec_mem_req_s MEM_REQ_O,
  input wire logic [7:0] MEM_RDATA_I,
  output iec_restore_s RESTORE_O,
  output iec_queue_s QUEUE_O,
  output logic IRQ_PENDING_O,
  output logic [4:0] VECTOR_NUM_O,
  output logic SEQ_BUSY_O
);

  // ************************************************************
  // declarations
  // ************************************************************
  iec_seq_e state_r;
  logic [2:0] cnt_r;
  logic [NSRC-1:0] src_flag_r;
  logic ext_flag_r;
  logic pin_prev_r;
  logic pin_level_r;
  logic pull_up_r;
  logic pull_dn_r;
  logic wake_r;
  logic pend_r;
  logic busy_r;
  logic [7:0] ccr_r;
  logic [15:0] sp_r;
  logic [4:0] vec_r;
  logic [15:0] target_r;
  logic [7:0] pch_r;
  logic [7:0] rest_a_r;
  logic [7:0] rest_x_r;
  iec_cpu_ctx_s ctx_r;
  iec_mem_req_s mem_r;
  iec_restore_s rest_r;
  iec_queue_s queue_r;
  logic pin_act;
  logic pin_edge;
  logic ext_req;
  logic wake_async;
  logic [NSRC:0] pend;
  logic pend_any;
  logic [4:0] enc_idx;
  logic start_entry;
  logic start_rti;
  logic [15:0] vec_addr;
  logic [15:0] fill_addr;
  logic [7:0] push_data;

  // ************************************************************
  // peripheral source flags
  // ************************************************************
  // one sticky flag per source; a new event beats a clear in the same cycle
  for (genvar g = 0; g < NSRC; g++) begin : g_flag
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        src_flag_r[g] <= 1'b0;
      end else if (SRC_EVENT_I[g]) begin
        src_flag_r[g] <= 1'b1;
      end else if (SRC_FLAG_CLR_I[g]) begin
        src_flag_r[g] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // external interrupt pin
  // ************************************************************
  // pin asserted means it sits at the selected polarity
  assign pin_act = (EXT_PIN_I == EXT_CFG_I.polarity_select);
  assign pin_edge = pin_act & ~pin_prev_r;

  // previous sampled assertion for edge detection
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_act & EXT_CFG_I.function_enable;
    end
  end

  // pin event flag; level mode keeps it set while the pin is asserted
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_flag_r <= 1'b0;
    end else if (EXT_CFG_I.function_enable && pin_edge) begin
      ext_flag_r <= 1'b1;
    end else if (EXT_CFG_I.function_enable && EXT_CFG_I.detect_mode && pin_act) begin
      ext_flag_r <= 1'b1;
    end else if (EXT_FLAG_ACK_I) begin
      ext_flag_r <= 1'b0;
    end
  end

  // pull device opposes the active polarity, level seen by branches
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pull_up_r <= 1'b0;
      pull_dn_r <= 1'b0;
      pin_level_r <= 1'b0;
    end else begin
      pull_up_r <= EXT_CFG_I.function_enable & ~EXT_CFG_I.pull_disable
                   & ~EXT_CFG_I.polarity_select;
      pull_dn_r <= EXT_CFG_I.function_enable & ~EXT_CFG_I.pull_disable
                   & EXT_CFG_I.polarity_select;
      pin_level_r <= EXT_CFG_I.function_enable & EXT_PIN_I;
    end
  end

  // stop wake: set without any clock edge, cleared once clocks run again
  assign wake_async = STOP_I & EXT_CFG_I.function_enable & pin_act;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I or posedge wake_async) begin
    if (!RESET_N_I) begin
      wake_r <= 1'b0;
    end else if (wake_async) begin
      wake_r <= 1'b1;
    end else begin
      wake_r <= 1'b0;
    end
  end

  // ************************************************************
  // request and priority
  // ************************************************************
  // interrupt mode only; poll mode leaves the flag alone
  assign ext_req = ext_flag_r & EXT_CFG_I.irq_enable & EXT_CFG_I.function_enable;
  assign pend = {src_flag_r & SRC_ENABLE_I, ext_req};
  assign pend_any = |pend;

  // lowest index wins: pin first, then sources in vector order
  always_comb begin
    enc_idx = 5'h00;
    for (int i = NSRC; i >= 0; i--) begin
      if (pend[i]) begin
        enc_idx = 5'(i);
      end
    end
  end

  // entry at an instruction boundary when unmasked, or by the instruction
  assign start_entry = (state_r == ST_IDLE)
                       && (SWI_REQ_I || (INSTR_DONE_I && pend_any
                                         && !ccr_r[`IEC_CCR_IBIT]));
  assign start_rti = (state_r == ST_IDLE) && RTI_REQ_I && !start_entry;

  // vector address and next fill address
  assign vec_addr = `IEC_VEC_TOP - {10'h000, vec_r, 1'b0};
  assign fill_addr = target_r + {13'h0000, cnt_r};

  // byte pushed at each step
  always_comb begin
    case (cnt_r)
      3'h0: push_data = ctx_r.pc[7:0];
      3'h1: push_data = ctx_r.pc[15:8];
      3'h2: push_data = ctx_r.x;
      3'h3: push_data = ctx_r.a;
      default: push_data = ccr_r;
    endcase
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // phase and step counter; hardware and software entry share one path
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 3'h0;
          if (start_entry) begin
            state_r <= ST_PUSH;
            busy_r <= 1'b1;
          end else if (start_rti) begin
            state_r <= ST_POP;
            busy_r <= 1'b1;
          end
        end
        ST_PUSH: begin
          if (cnt_r == `IEC_PUSH_LAST) begin
            state_r <= ST_VEC;
            cnt_r <= 3'h0;
          end
        end
        ST_VEC: begin
          if (cnt_r == `IEC_VEC_LAST) begin
            state_r <= ST_FILL;
            cnt_r <= 3'h0;
          end
        end
        ST_POP: begin
          if (cnt_r == `IEC_POP_LAST) begin
            state_r <= ST_FILL;
            cnt_r <= 3'h0;
          end
        end
        ST_FILL: begin
          if (cnt_r == `IEC_FILL_LAST) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // context and vector latched when entry starts
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctx_r <= '0;
      vec_r <= 5'h00;
    end else if (start_entry) begin
      ctx_r <= CPU_CTX_I;
      vec_r <= SWI_REQ_I ? `IEC_SWI_VEC : 5'(`IEC_EXT_VEC + enc_idx);
    end
  end

  // ************************************************************
  // condition codes and stack pointer
  // ************************************************************
  // mask set by reset and entry, restored by return, else software
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ccr_r <= `IEC_CCR_RST;
    end else if (state_r == ST_PUSH && cnt_r == `IEC_PUSH_LAST) begin
      ccr_r[`IEC_CCR_IBIT] <= 1'b1;
    end else if (state_r == ST_POP && cnt_r == `IEC_RD_LAT) begin
      ccr_r <= MEM_RDATA_I;
    end else if (state_r == ST_IDLE && CCR_WR_I) begin
      ccr_r <= CCR_WDATA_I;
    end
  end

  // post-decrement on push, pre-increment on pop
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sp_r <= `IEC_SP_RST;
    end else if (state_r == ST_PUSH) begin
      sp_r <= sp_r - 16'h0001;
    end else if (state_r == ST_POP && cnt_r <= `IEC_PUSH_LAST) begin
      sp_r <= sp_r + 16'h0001;
    end else if (state_r == ST_IDLE && SP_WR_I) begin
      sp_r <= SP_WDATA_I;
    end
  end

  // ************************************************************
  // memory requests
  // ************************************************************
  // one byte per cycle; read data returns two steps after issue
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mem_r <= '0;
    end else begin
      mem_r.rd <= 1'b0;
      mem_r.wr <= 1'b0;
      case (state_r)
        ST_PUSH: begin
          mem_r.wr <= 1'b1;
          mem_r.addr <= sp_r;
          mem_r.wdata <= push_data;
        end
        ST_VEC: begin
          if (cnt_r < `IEC_RD_LAT) begin
            mem_r.rd <= 1'b1;
            mem_r.addr <= vec_addr + {15'h0000, cnt_r[0]};
          end
        end
        ST_POP: begin
          if (cnt_r <= `IEC_PUSH_LAST) begin
            mem_r.rd <= 1'b1;
            mem_r.addr <= sp_r + 16'h0001;
          end
        end
        ST_FILL: begin
          if (cnt_r < 3'h3) begin
            mem_r.rd <= 1'b1;
            mem_r.addr <= fill_addr;
          end
        end
        default: begin
          mem_r.rd <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // read capture
  // ************************************************************
  // vector and popped bytes land in the fill target and restore set
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      target_r <= 16'h0000;
      pch_r <= 8'h00;
      rest_a_r <= 8'h00;
      rest_x_r <= 8'h00;
    end else if (state_r == ST_VEC) begin
      if (cnt_r == `IEC_RD_LAT) begin
        pch_r <= MEM_RDATA_I;
      end else if (cnt_r == `IEC_VEC_LAST) begin
        target_r <= {pch_r, MEM_RDATA_I};
      end
    end else if (state_r == ST_POP) begin
      case (cnt_r)
        3'h3: rest_a_r <= MEM_RDATA_I;
        3'h4: rest_x_r <= MEM_RDATA_I;
        3'h5: pch_r <= MEM_RDATA_I;
        3'h6: target_r <= {pch_r, MEM_RDATA_I};
        default: pch_r <= pch_r;
      endcase
    end
  end

  // restore pulse ends the pop, queue pulses carry the three fill bytes
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rest_r <= '0;
      queue_r <= '0;
    end else begin
      rest_r.valid <= 1'b0;
      queue_r.valid <= 1'b0;
      if (state_r == ST_POP && cnt_r == `IEC_POP_LAST) begin
        rest_r.valid <= 1'b1;
        rest_r.a <= rest_a_r;
        rest_r.x <= rest_x_r;
        rest_r.pc <= {pch_r, MEM_RDATA_I};
      end
      if (state_r == ST_FILL && cnt_r >= `IEC_RD_LAT) begin
        queue_r.valid <= 1'b1;
        queue_r.addr <= fill_addr - 16'h0002;
        queue_r.data <= MEM_RDATA_I;
      end
    end
  end

  // registered request summary
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_any;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SRC_FLAG_O = src_flag_r;
  assign EXT_PIN_EVENT_FLAG_O = ext_flag_r;
  assign EXT_PIN_LEVEL_O = pin_level_r;
  assign EXT_PULL_UP_EN_O = pull_up_r;
  assign EXT_PULL_DOWN_EN_O = pull_dn_r;
  assign STOP_WAKE_O = wake_r;
  assign CCR_O = ccr_r;
  assign SP_O = sp_r;
  assign MEM_REQ_O = mem_r;
  assign RESTORE_O = rest_r;
  assign QUEUE_O = queue_r;
  assign IRQ_PENDING_O = pend_r;
  assign VECTOR_NUM_O = vec_r;
  assign SEQ_BUSY_O = busy_r;

endmodule // iec_irq_ctrl

// *** rtl/iec_regs.svh ***
// constants for the interrupt entry and external pin block
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

// condition code register: global mask position and reset value
`define IEC_CCR_IBIT 3
`define IEC_CCR_RST 8'h08

// stack pointer value after reset
`define IEC_SP_RST 16'h00FF

// vector table: number 0 sits at the top, each vector two bytes
`define IEC_VEC_TOP 16'hFFFE
`define IEC_SWI_VEC 5'h01
`define IEC_EXT_VEC 5'h02

// last step count of each sequencer phase
`define IEC_PUSH_LAST 3'h4
`define IEC_VEC_LAST 3'h3
`define IEC_FILL_LAST 3'h4
`define IEC_POP_LAST 3'h6

// step at which the first read byte is captured (two-cycle read path)
`define IEC_RD_LAT 3'h2

`endif

// *** rtl/iec_pkg.sv ***
// types shared by the interrupt entry and external pin block
package iec_pkg;

  // sequencer phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH,
    ST_VEC,
    ST_FILL,
    ST_POP
  } iec_seq_e;

  // external pin configuration bits
  typedef struct packed {
    logic function_enable;
    logic polarity_select;
    logic detect_mode;
    logic irq_enable;
    logic pull_disable;
  } iec_ext_cfg_s;

  // core context to be stacked on entry
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] x;
  } iec_cpu_ctx_s;

  // memory request toward the system bus
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iec_mem_req_s;

  // context recovered by the return sequence
  typedef struct packed {
    logic valid;
    logic [7:0] a;
    logic [7:0] x;
    logic [15:0] pc;
  } iec_restore_s;

  // instruction queue fill byte
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } iec_queue_s;

endpackage : iec_pkg

// *** bench/iec_mem_model.sv ***
// memory beside the sequencer: stack, vector table and program bytes
`timescale 1ns/100ps
module iec_mem_model
  import iec_pkg::*;
(
  input wire logic clk_i,
  input wire iec_mem_req_s req_i,
  output logic [7:0] rdata_o
);
  // ****************
  // storage and read path
  // ****************
  logic [7:0] mem_r [logic [15:0]];

  // unwritten bytes follow an address pattern, vector high byte first
  function automatic logic [7:0] fetch(input logic [15:0] a);
    if (mem_r.exists(a)) return mem_r[a];
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // read data valid the cycle after the request, toggling once released
  initial rdata_o = 8'h00;
  always @(posedge clk_i) begin
    if (req_i.wr === 1'b1) mem_r[req_i.addr] = req_i.wdata;
    if (req_i.rd === 1'b1) rdata_o <= fetch(req_i.addr);
    else rdata_o <= ~rdata_o;
  end
endmodule // iec_mem_model

// *** bench/iec_irq_ctrl_monitor.sv ***
// port checker for the interrupt entry and external pin block
`timescale 1ns/100ps
`include "iec_regs.svh"
module iec_irq_ctrl_monitor
  import iec_pkg::*;
#(
  parameter int NSRC = 29
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [NSRC-1:0] SRC_EVENT_I,
  input wire logic [NSRC-1:0] SRC_FLAG_O,
  input wire logic EXT_PIN_I,
  input wire iec_ext_cfg_s EXT_CFG_I,
  input wire logic EXT_PIN_EVENT_FLAG_O,
  input wire logic STOP_I,
  input wire logic STOP_WAKE_O,
  input wire logic INSTR_DONE_I,
  input wire logic SWI_REQ_I,
  input wire logic RTI_REQ_I,
  input wire logic [7:0] CCR_O,
  input wire iec_mem_req_s MEM_REQ_O,
  input wire iec_queue_s QUEUE_O,
  input wire logic SEQ_BUSY_O
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // pin asserted in edge-and-level mode
  wire logic lvl = EXT_CFG_I.function_enable & EXT_CFG_I.detect_mode &
    (EXT_PIN_I == EXT_CFG_I.polarity_select);
  property p_flag_set;
    SRC_EVENT_I != '0 |=> (SRC_FLAG_O & $past(SRC_EVENT_I)) == $past(SRC_EVENT_I);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag missed");
  property p_entry_qual;
    $rose(SEQ_BUSY_O) && !$past(SWI_REQ_I) && !$past(RTI_REQ_I)
      |-> $past(INSTR_DONE_I) && !$past(CCR_O[`IEC_CCR_IBIT]);
  endproperty
  a_entry_qual: assert property (p_entry_qual) else $error("bad entry");
  property p_push_order;
    MEM_REQ_O.wr && $past(MEM_REQ_O.wr) |-> MEM_REQ_O.addr == $past(MEM_REQ_O.addr) - 16'h1;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push addr");
  property p_mask_set;
    $fell(MEM_REQ_O.wr) |-> ##[0:2] CCR_O[`IEC_CCR_IBIT];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask clear");
  property p_read_pair;
    MEM_REQ_O.rd && $past(MEM_REQ_O.rd) |-> MEM_REQ_O.addr == $past(MEM_REQ_O.addr) + 16'h1;
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("read addr");
  property p_fill_three;
    $rose(QUEUE_O.valid) |-> QUEUE_O.valid [*3] ##1 !QUEUE_O.valid;
  endproperty
  a_fill_three: assert property (p_fill_three) else $error("fill count");
  property p_level_hold;
    lvl [*2] |=> EXT_PIN_EVENT_FLAG_O;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level flag");
  property p_wake;
    STOP_I && EXT_CFG_I.function_enable && EXT_PIN_I == EXT_CFG_I.polarity_select
      |-> STOP_WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  // main scenarios
  c_entry: cover property ($rose(SEQ_BUSY_O) && $past(INSTR_DONE_I));
  c_swi: cover property ($rose(SEQ_BUSY_O) && $past(SWI_REQ_I));
  c_ret: cover property ($rose(SEQ_BUSY_O) && $past(RTI_REQ_I));
endmodule // iec_irq_ctrl_monitor

bind iec_irq_ctrl iec_irq_ctrl_monitor #(.NSRC(NSRC)) u_mon (.REF_CLK_I(REF_CLK_I),
  .RESET_N_I(RESET_N_I), .SRC_EVENT_I(SRC_EVENT_I), .SRC_FLAG_O(SRC_FLAG_O),
  .EXT_PIN_I(EXT_PIN_I), .EXT_CFG_I(EXT_CFG_I), .EXT_PIN_EVENT_FLAG_O(EXT_PIN_EVENT_FLAG_O),
  .STOP_I(STOP_I), .STOP_WAKE_O(STOP_WAKE_O), .INSTR_DONE_I(INSTR_DONE_I),
  .SWI_REQ_I(SWI_REQ_I), .RTI_REQ_I(RTI_REQ_I), .CCR_O(CCR_O), .MEM_REQ_O(MEM_REQ_O),
  .QUEUE_O(QUEUE_O), .SEQ_BUSY_O(SEQ_BUSY_O));

// *** bench/test_interrupt_entry_and_irq_pin.sv ***
// self-checking bench for the interrupt entry and external pin block
`timescale 1ns/100ps
`include "iec_regs.svh"
module test_interrupt_entry_and_irq_pin;
  import iec_pkg::*;
  // ****************
  // signals and model state
  // ****************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [28:0] ev = '0, fclr = '0, en = '0, flg;
  logic pin = 1'b0, ack = 1'b0, stp = 1'b0, done = 1'b0, software_interrupt_instruction = 1'b0, return_from_interrupt_instruction = 1'b0;
  logic cwr = 1'b0, swr = 1'b0, efl, elv, pu, pdn, wake, pend, busy;
  logic [7:0] cwd = 8'h00, rdat, condition_code_register, m_ccr;
  logic [15:0] swd = 16'h0000, sp, m_sp;
  logic [4:0] vnum;
  iec_ext_cfg_s cfg = '0;
  iec_cpu_ctx_s ctx = '0, st;
  iec_mem_req_s req;
  iec_restore_s rso, rs;
  iec_queue_s qo;
  logic [23:0] wq[$], qq[$];
  int mismatches = 0, comparisons = 0, cyc = 0, a, b;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  iec_irq_ctrl DUT (.REF_CLK_I(clk), .RESET_N_I(rst_n), .SRC_EVENT_I(ev),
    .SRC_FLAG_CLR_I(fclr), .SRC_ENABLE_I(en), .SRC_FLAG_O(flg), .EXT_PIN_I(pin),
    .EXT_CFG_I(cfg), .EXT_FLAG_ACK_I(ack), .EXT_PIN_EVENT_FLAG_O(efl), .EXT_PIN_LEVEL_O(elv),
    .EXT_PULL_UP_EN_O(pu), .EXT_PULL_DOWN_EN_O(pdn), .STOP_I(stp), .STOP_WAKE_O(wake),
    .CPU_CTX_I(ctx), .INSTR_DONE_I(done), .SWI_REQ_I(software_interrupt_instruction), .RTI_REQ_I(return_from_interrupt_instruction), .CCR_WR_I(cwr),
    .CCR_WDATA_I(cwd), .SP_WR_I(swr), .SP_WDATA_I(swd), .CCR_O(condition_code_register), .SP_O(sp),
    .MEM_REQ_O(req), .MEM_RDATA_I(rdat), .RESTORE_O(rso), .QUEUE_O(qo),
    .IRQ_PENDING_O(pend), .VECTOR_NUM_O(vnum), .SEQ_BUSY_O(busy));
  iec_mem_model u_mem (.clk_i(clk), .req_i(req), .rdata_o(rdat));

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] mb(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // capture writes, fill bytes and restore pulses; cut a hang short
  always @(posedge clk) begin
    if (req.wr === 1'b1) wq.push_back({req.addr, req.wdata});
    if (qo.valid === 1'b1) qq.push_back({qo.addr, qo.data});
    if (rso.valid === 1'b1) rs = rso;
    cyc++;
    if (cyc > 4000) begin
      mismatches++;
      results();
    end
  end
  task automatic seq_wait;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n < 60, 1);
    repeat (3) @(negedge clk);
  endtask
  task automatic fill(input logic [15:0] t);
    chk(qq.size(), 3);
    for (int k = 0; k < 3; k++) chk(qq[k], {t + 16'(k), mb(t + 16'(k))});
  endtask
  task automatic entry(input logic [4:0] vec, input logic by_swi);
    logic [15:0] va;
    logic [7:0] w[5];
    ctx = {1'b1, 15'($urandom), 16'($urandom)};
    wq.delete();
    qq.delete();
    if (by_swi) software_interrupt_instruction = 1'b1;
    else done = 1'b1;
    @(negedge clk);
    software_interrupt_instruction = 1'b0;
    done = 1'b0;
    seq_wait();
    w = '{ctx.pc[7:0], ctx.pc[15:8], ctx.x, ctx.a, m_ccr};
    chk(wq.size(), 5);
    for (int k = 0; k < 5; k++) chk(wq[k], {m_sp - 16'(k), w[k]});
    m_sp = m_sp - 16'h5;
    chk({sp, condition_code_register[`IEC_CCR_IBIT], vnum}, {m_sp, 1'b1, vec});
    va = `IEC_VEC_TOP - 16'(2 * vec);
    fill({mb(va), mb(va + 16'h1)});
    st = ctx;
    rs = '0;
  endtask
  task automatic ret;
    qq.delete();
    return_from_interrupt_instruction = 1'b1;
    @(negedge clk);
    return_from_interrupt_instruction = 1'b0;
    seq_wait();
    chk({rs.valid, rs.pc, rs.a, rs.x}, {1'b1, st.pc, st.a, st.x});
    m_sp = m_sp + 16'h5;
    chk({sp, condition_code_register}, {m_sp, m_ccr});
    fill(st.pc);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(96520));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    m_ccr = `IEC_CCR_RST;
    m_sp = `IEC_SP_RST;
    chk({condition_code_register, sp}, {m_ccr, m_sp});
    // pull device over enable, polarity and disable
    for (int i = 0; i < 8; i++) begin
      cfg = {i[0], i[1], 1'b0, 1'b1, i[2]};
      repeat (2) @(negedge clk);
      chk({pu, pdn}, {i[0] & ~i[2] & ~i[1], i[0] & ~i[2] & i[1]});
    end
    // pin edge, level, poll and stop wake, both polarities
    for (int p = 0; p < 2; p++) begin
      cfg = {1'b1, p[0], 1'b0, 1'b1, 1'b0};
      pin = ~p[0];
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      repeat (2) @(negedge clk);
      chk(efl, 0);
      pin = p[0];
      repeat (2) @(negedge clk);
      chk({efl, elv, pend}, {1'b1, p[0], 1'b1});
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      cfg.detect_mode = 1'b1;
      cfg.irq_enable = 1'b0;
      repeat (2) @(negedge clk);
      chk({efl, pend}, 2'b10);
      pin = ~p[0];
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      cfg.function_enable = 1'b0;
      repeat (2) @(negedge clk);
      chk({efl, elv}, 2'b00);
      pin = p[0];
      repeat (2) @(negedge clk);
      chk(efl, 0);
      cfg = {1'b1, p[0], 1'b0, 1'b0, 1'b0};
      pin = ~p[0];
      stp = 1'b1;
      repeat (2) @(negedge clk);
      pin = p[0];
      #1;
      chk(wake, 1);
      @(negedge clk);
      stp = 1'b0;
      pin = ~p[0];
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      chk(wake, 0);
    end
    cfg = '0;
    // two sources pending while masked
    a = $urandom_range(0, 27);
    b = $urandom_range(a + 1, 28);
    en = 29'($urandom) | (29'h1 << a) | (29'h1 << b);
    ev = (29'h1 << a) | (29'h1 << b);
    @(negedge clk);
    ev = '0;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    repeat (2) @(negedge clk);
    chk({busy, pend, efl}, 3'b010);
    chk(flg, (29'h1 << a) | (29'h1 << b));
    swd = {8'h01, 8'($urandom)};
    cwr = 1'b1;
    swr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    swr = 1'b0;
    @(negedge clk);
    m_sp = swd;
    m_ccr = 8'h00;
    chk({sp, condition_code_register}, {m_sp, m_ccr});
    entry(5'(3 + a), 1'b0);
    fclr = 29'h1 << a;
    @(negedge clk);
    fclr = '0;
    chk(flg, 29'h1 << b);
    ret();
    entry(5'(3 + b), 1'b0);
    fclr = 29'h1 << b;
    @(negedge clk);
    fclr = '0;
    chk(flg, 0);
    ret();
    entry(`IEC_SWI_VEC, 1'b1);
    ret();
    results();
  end
endmodule // test_interrupt_entry_and_irq_pin
